// ===== rtl/agh_device.sv
// Receive gain supervision device: event counters, decision period, GPIO override.
// Assumes detector events arrive as one-cycle pulses on the reference clock and
// that the link pins come from another party, so they are synchronised here.
`timescale 1ns/1ps
module agh_device (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  agh_link_if.dev link,
  input wire logic [agh_pkg::AGH_NUM_CH-1:0] i_over_evt,
  input wire logic [agh_pkg::AGH_NUM_CH-1:0] i_under_evt,
  input wire logic [agh_pkg::AGH_CNT_W-1:0] i_over_thresh,
  input wire logic [agh_pkg::AGH_CNT_W-1:0] i_under_thresh,
  input wire logic [agh_pkg::AGH_PERIOD_W-1:0] i_period_len,
  input wire logic i_holdover_en,
  input wire logic i_reset_state_on_rx_disable,
  input wire logic [agh_pkg::AGH_SEL_W-1:0] i_ovr_pin_sel,
  input wire logic [agh_pkg::AGH_GPIO_W-1:0] i_trig_unmask,
  input wire logic [agh_pkg::AGH_GAIN_W-1:0] i_manual_gain,
  input wire logic i_sync_en,
  input wire logic [agh_pkg::AGH_SEL_W-1:0] i_sync_pin_sel,
  input wire logic i_pin_gain_en,
  input wire logic i_mon_en,
  input wire logic [agh_pkg::AGH_GAIN_W-1:0] i_gain_min,
  input wire logic [agh_pkg::AGH_GAIN_W-1:0] i_gain_max,
  output logic [agh_pkg::AGH_NUM_CH*agh_pkg::AGH_GAIN_W-1:0] o_gain_idx,
  output logic o_manual_gain_mode,
  output logic o_peak_reset,
  output logic [agh_pkg::AGH_NUM_CH-1:0] o_over_trig,
  output logic [agh_pkg::AGH_NUM_CH-1:0] o_under_trig
);
  import agh_pkg::*;

  typedef struct packed {
    logic [AGH_GPIO_W-1:0] gp_s1;
    logic [AGH_GPIO_W-1:0] gp_s2;
    logic [AGH_GPIO_W-1:0] gp_d;
    logic rx_s1;
    logic rx_s2;
    logic rx_d;
    agh_mode_t mode;
    logic [AGH_NUM_CH-1:0][AGH_GAIN_W-1:0] gain;
    logic [AGH_NUM_CH-1:0][AGH_CNT_W-1:0] ov_cnt;
    logic [AGH_NUM_CH-1:0][AGH_CNT_W-1:0] un_cnt;
    logic [AGH_PERIOD_W-1:0] per_cnt;
    logic peak_rst;
    logic [AGH_NUM_CH-1:0] ov_trig;
    logic [AGH_NUM_CH-1:0] un_trig;
    logic [AGH_MON_W-1:0] mon;
    logic manual;
  } agh_dev_st_t;

  agh_dev_st_t st_ff;
  agh_dev_st_t nxt_st;

  // Saturating accumulate; a clear in the same cycle as an event keeps the event
  function automatic logic [AGH_CNT_W-1:0] agh_acc(
    input logic [AGH_CNT_W-1:0] cnt,
    input logic clr,
    input logic evt
  );
    logic [AGH_CNT_W-1:0] base;
    base = clr ? '0 : cnt;
    if (evt && (base != AGH_CNT_MAX))
    begin
      base = base + 8'h01;
    end
    return base;
  endfunction : agh_acc

  logic rx_fall;
  logic [AGH_GPIO_W-1:0] gp_rise;
  logic ovr_lvl;
  logic slot_rise;
  logic expiry;
  logic clr_all;
  logic [AGH_GAIN_W-1:0] pin_gain;

  // Edge and level decode, on second stage and delayed copy only
  always_comb
  begin
    rx_fall = st_ff.rx_d & ~st_ff.rx_s2;
    gp_rise = st_ff.gp_s2 & ~st_ff.gp_d;
    ovr_lvl = st_ff.gp_s2[i_ovr_pin_sel] & i_trig_unmask[i_ovr_pin_sel];
    slot_rise = i_sync_en & gp_rise[i_sync_pin_sel];
    expiry = (st_ff.per_cnt == '0);
    pin_gain = st_ff.gp_s2[AGH_PIN_GAIN_LSB +: AGH_GAIN_W];
    // Counter clearing: each period, and on rx enable fall unless holdover
    clr_all = expiry | (rx_fall & ~i_holdover_en);
  end

  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    // Two-flop synchronisers plus a delayed copy for edges
    nxt_st.gp_s1 = link.gpio;
    nxt_st.gp_s2 = st_ff.gp_s1;
    nxt_st.gp_d = st_ff.gp_s2;
    nxt_st.rx_s1 = link.rx_en;
    nxt_st.rx_s2 = st_ff.rx_s1;
    nxt_st.rx_d = st_ff.rx_s2;

    // Decision period: reload on slot edge or expiry, else count down
    if (slot_rise || expiry)
    begin
      nxt_st.per_cnt = i_period_len;
    end
    else
    begin
      nxt_st.per_cnt = st_ff.per_cnt - 22'h000001;
    end
    nxt_st.peak_rst = expiry;

    // Monitor pins follow detector flags one cycle later, registered, while enabled
    nxt_st.mon = i_mon_en ? {i_under_evt, i_over_evt} : '0;

    nxt_st.ov_trig = '0;
    nxt_st.un_trig = '0;

    // Per-channel event accumulation and AGC triggers
    for (int ch = 0; ch < AGH_NUM_CH; ch++)
    begin
      logic ov_hit;
      logic un_hit;
      ov_hit = (st_ff.ov_cnt[ch] > i_over_thresh) && (st_ff.mode == AGH_ST_AGC);
      un_hit = (st_ff.un_cnt[ch] > i_under_thresh) && (st_ff.mode == AGH_ST_AGC);
      nxt_st.ov_cnt[ch] = agh_acc(st_ff.ov_cnt[ch], clr_all | ov_hit, i_over_evt[ch]);
      nxt_st.un_cnt[ch] = agh_acc(st_ff.un_cnt[ch], clr_all | un_hit, i_under_evt[ch]);
      nxt_st.ov_trig[ch] = ov_hit;
      nxt_st.un_trig[ch] = un_hit & ~ov_hit;
      // Overrange attacks before underrange recovers
      // Limits compared before stepping so the index never wraps at 0 or 255
      if (ov_hit)
      begin
        if (st_ff.gain[ch] > i_gain_min)
        begin
          nxt_st.gain[ch] = st_ff.gain[ch] - AGH_GAIN_STEP;
        end
        else
        begin
          nxt_st.gain[ch] = i_gain_min;
        end
      end
      else if (un_hit)
      begin
        if (st_ff.gain[ch] < i_gain_max)
        begin
          nxt_st.gain[ch] = st_ff.gain[ch] + AGH_GAIN_STEP;
        end
        else
        begin
          nxt_st.gain[ch] = i_gain_max;
        end
      end
    end

    // Gain control mode selection
    case (st_ff.mode)
      AGH_ST_AGC:
      begin
        if (ovr_lvl)
        begin
          nxt_st.mode = AGH_ST_OVERRIDE;
          for (int ch = 0; ch < AGH_NUM_CH; ch++)
          begin
            nxt_st.gain[ch] = i_manual_gain;
          end
        end
        else if (i_pin_gain_en)
        begin
          nxt_st.mode = AGH_ST_PIN;
        end
        else if (i_reset_state_on_rx_disable && rx_fall)
        begin
          // Receiver disabled: restart loop from maximum gain
          for (int ch = 0; ch < AGH_NUM_CH; ch++)
          begin
            nxt_st.gain[ch] = i_gain_max;
            nxt_st.ov_cnt[ch] = '0;
            nxt_st.un_cnt[ch] = '0;
          end
          nxt_st.per_cnt = i_period_len;
        end
      end
      AGH_ST_OVERRIDE:
      begin
        // Gain stays at the fixed index; loop updates are discarded
        nxt_st.gain = st_ff.gain;
        if (!ovr_lvl)
        begin
          nxt_st.mode = AGH_ST_AGC;
        end
      end
      AGH_ST_PIN:
      begin
        for (int ch = 0; ch < AGH_NUM_CH; ch++)
        begin
          nxt_st.gain[ch] = pin_gain;
        end
        if (ovr_lvl)
        begin
          nxt_st.mode = AGH_ST_OVERRIDE;
          for (int ch = 0; ch < AGH_NUM_CH; ch++)
          begin
            nxt_st.gain[ch] = i_manual_gain;
          end
        end
        else if (!i_pin_gain_en)
        begin
          nxt_st.mode = AGH_ST_AGC;
        end
      end
      default:
      begin
        nxt_st.mode = AGH_ST_AGC;
      end
    endcase
    // Manual flag registered so the output comes from a flop
    nxt_st.manual = (nxt_st.mode != AGH_ST_AGC);
  end

  // State register
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st_ff <= '0;
      st_ff.mode <= AGH_ST_AGC;
      st_ff.gain <= {AGH_NUM_CH{AGH_GAIN_RST}};
      st_ff.per_cnt <= AGH_PERIOD_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign o_gain_idx = st_ff.gain;
  assign o_manual_gain_mode = st_ff.manual;
  assign o_peak_reset = st_ff.peak_rst;
  assign o_over_trig = st_ff.ov_trig;
  assign o_under_trig = st_ff.un_trig;
  assign link.mon = st_ff.mon;
endmodule : agh_device

// ===== include/agh_pkg.sv
// Shared constants and types for the receive gain supervision link.
// Assumes both ends run on one 25 MHz reference clock with a synchronous reset.
package agh_pkg;
  // Link shape
  localparam int AGH_NUM_CH = 4;
  localparam int AGH_GPIO_W = 16;
  localparam int AGH_SEL_W = 4;
  localparam int AGH_GAIN_W = 8;
  localparam int AGH_CNT_W = 8;
  localparam int AGH_MON_W = 2 * AGH_NUM_CH;
  // Pin gain byte sits on the upper GPIO half
  localparam int AGH_PIN_GAIN_LSB = 8;
  // Decision period counter
  localparam int AGH_PERIOD_W = 22;
  localparam logic [AGH_PERIOD_W-1:0] AGH_PERIOD_MAX = 22'h3FFFFF;
  localparam logic [AGH_PERIOD_W-1:0] AGH_PERIOD_RST = 22'h000000;
  // Gain defaults
  localparam logic [AGH_GAIN_W-1:0] AGH_GAIN_RST = 8'hFF;
  localparam logic [AGH_GAIN_W-1:0] AGH_GAIN_STEP = 8'h01;
  localparam logic [AGH_CNT_W-1:0] AGH_CNT_MAX = 8'hFF;
  // Controller register map (byte addresses)
  localparam int AGH_ADDR_W = 8;
  localparam logic [AGH_ADDR_W-1:0] AGH_REG_CTRL = 8'h00;
  localparam logic [AGH_ADDR_W-1:0] AGH_REG_GPIO = 8'h04;
  localparam logic [AGH_ADDR_W-1:0] AGH_REG_SLOT = 8'h08;
  localparam logic [AGH_ADDR_W-1:0] AGH_REG_MON = 8'h0C;
  localparam logic [AGH_ADDR_W-1:0] AGH_REG_IRQ_STAT = 8'h10;
  localparam logic [AGH_ADDR_W-1:0] AGH_REG_IRQ_CLR = 8'h14;
  localparam logic [AGH_ADDR_W-1:0] AGH_REG_IRQ_EN = 8'h18;
  // Field positions
  localparam int AGH_CTRL_RX_EN_BIT = 0;
  localparam int AGH_SLOT_PULSE_CYC_W = 3;
  localparam logic [AGH_SLOT_PULSE_CYC_W-1:0] AGH_SLOT_PULSE_CYC = 3'h4;
  // Device gain control modes
  typedef enum logic [1:0] {AGH_ST_AGC, AGH_ST_OVERRIDE, AGH_ST_PIN} agh_mode_t;
endpackage : agh_pkg

// ===== include/agh_link_if.sv
// Pin bundle between the baseband controller and the gain supervision device.
// Assumes both ends share one clock; no tri-state pins are carried.
`timescale 1ns/1ps
interface agh_link_if;
  import agh_pkg::*;
  logic rx_en;
  logic [AGH_GPIO_W-1:0] gpio;
  logic [AGH_MON_W-1:0] mon;
  modport dev (input rx_en, input gpio, output mon);
  modport host (output rx_en, output gpio, input mon);
endinterface : agh_link_if

// ===== rtl/agh_host.sv
// Baseband-side controller: drives rx enable and GPIO pins from Avalon-MM registers
// and raises an interrupt on monitor flag rising edges.
// Assumes an Avalon-MM master with waitrequest on the same clock.
`timescale 1ns/1ps
module agh_host (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  agh_link_if.host link,
  input wire logic [agh_pkg::AGH_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq
);
  import agh_pkg::*;

  typedef struct packed {
    logic wait_req;
    logic [31:0] rdata;
    logic rx_en;
    logic [AGH_GPIO_W-1:0] gpio_reg;
    logic [AGH_GPIO_W-1:0] gpio_out;
    logic [AGH_SEL_W-1:0] slot_pin;
    logic [AGH_SLOT_PULSE_CYC_W-1:0] slot_cnt;
    logic [AGH_MON_W-1:0] mon_s1;
    logic [AGH_MON_W-1:0] mon_s2;
    logic [AGH_MON_W-1:0] mon_d;
    logic [AGH_MON_W-1:0] irq_stat;
    logic [AGH_MON_W-1:0] irq_en;
    logic irq;
  } agh_host_st_t;

  agh_host_st_t st_ff;
  agh_host_st_t nxt_st;
  logic acc;
  logic [AGH_MON_W-1:0] clr;

  always_comb
  begin
    nxt_st = st_ff;
    clr = '0;
    // Answer one cycle after the request is seen
    acc = (i_avs_read | i_avs_write) & st_ff.wait_req;
    nxt_st.wait_req = ~acc;
    nxt_st.mon_s1 = link.mon;
    nxt_st.mon_s2 = st_ff.mon_s1;
    nxt_st.mon_d = st_ff.mon_s2;
    if (acc && i_avs_read)
    begin
      case (i_avs_address)
        AGH_REG_CTRL: nxt_st.rdata = {31'h0, st_ff.rx_en};
        AGH_REG_GPIO: nxt_st.rdata = {16'h0, st_ff.gpio_reg};
        AGH_REG_MON: nxt_st.rdata = {24'h0, st_ff.mon_s2};
        AGH_REG_IRQ_STAT: nxt_st.rdata = {24'h0, st_ff.irq_stat};
        AGH_REG_IRQ_EN: nxt_st.rdata = {24'h0, st_ff.irq_en};
        default: nxt_st.rdata = 32'h0;
      endcase
    end
    // Slot pulse counts down on every cycle until it reaches zero; a SLOT write reloads it below
    if (st_ff.slot_cnt != '0)
    begin
      nxt_st.slot_cnt = st_ff.slot_cnt - 3'h1;
    end
    // Writes land on the edge where waitrequest is seen low
    if (!st_ff.wait_req && i_avs_write)
    begin
      case (i_avs_address)
        AGH_REG_CTRL: nxt_st.rx_en = i_avs_writedata[AGH_CTRL_RX_EN_BIT];
        AGH_REG_GPIO: nxt_st.gpio_reg = i_avs_writedata[AGH_GPIO_W-1:0];
        AGH_REG_SLOT:
        begin
          nxt_st.slot_pin = i_avs_writedata[AGH_SEL_W-1:0];
          nxt_st.slot_cnt = AGH_SLOT_PULSE_CYC;
        end
        AGH_REG_IRQ_CLR: clr = i_avs_writedata[AGH_MON_W-1:0];
        AGH_REG_IRQ_EN: nxt_st.irq_en = i_avs_writedata[AGH_MON_W-1:0];
        default: nxt_st.rx_en = st_ff.rx_en;
      endcase
    end
    // Slot pulse rides on top of the static pin levels
    nxt_st.gpio_out = nxt_st.gpio_reg;
    if (nxt_st.slot_cnt != '0)
    begin
      nxt_st.gpio_out[nxt_st.slot_pin] = 1'b1;
    end
    // Sticky flags: a new edge wins over a clear
    nxt_st.irq_stat = (st_ff.irq_stat & ~clr) | (st_ff.mon_s2 & ~st_ff.mon_d);
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_en);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st_ff <= '0;
      st_ff.wait_req <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign o_avs_readdata = st_ff.rdata;
  assign o_avs_waitrequest = st_ff.wait_req;
  assign o_irq = st_ff.irq;
  assign link.rx_en = st_ff.rx_en;
  assign link.gpio = st_ff.gpio_out;
endmodule : agh_host

// ===== verif/agh_properties.sv
// Checker for the gain supervision link and the device outputs.
// Assumes one clock and a synchronous active-high reset shared by both ends.
`timescale 1ns/1ps
module agh_properties (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic rx_en,
  input wire logic [agh_pkg::AGH_GPIO_W-1:0] gpio,
  input wire logic [agh_pkg::AGH_MON_W-1:0] mon,
  input wire logic [agh_pkg::AGH_NUM_CH-1:0] i_over_evt,
  input wire logic [agh_pkg::AGH_NUM_CH-1:0] i_under_evt,
  input wire logic i_mon_en,
  input wire logic i_pin_gain_en,
  input wire logic [agh_pkg::AGH_SEL_W-1:0] i_ovr_pin_sel,
  input wire logic [agh_pkg::AGH_GPIO_W-1:0] i_trig_unmask,
  input wire logic [agh_pkg::AGH_GAIN_W-1:0] i_manual_gain,
  input wire logic [agh_pkg::AGH_PERIOD_W-1:0] i_period_len,
  input wire logic [agh_pkg::AGH_NUM_CH*agh_pkg::AGH_GAIN_W-1:0] o_gain_idx,
  input wire logic o_manual_gain_mode,
  input wire logic o_peak_reset,
  input wire logic [agh_pkg::AGH_NUM_CH-1:0] o_over_trig
);
  import agh_pkg::*;
  logic [AGH_PERIOD_W:0] since_ff;
  logic [AGH_GPIO_W-1:0] pins_ff;
  logic rx_ff;
  // Cycles since the last expiry or pin change (slot edge or rx disable may reload the period)
  always_ff @(posedge i_ref_clk)
  begin
    pins_ff <= gpio;
    rx_ff <= rx_en;
    since_ff <= (i_rst || o_peak_reset || gpio != pins_ff || rx_en != rx_ff) ? '0 : since_ff + 1'b1;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  AST_MON_ECHO: assert property (mon == ($past(i_mon_en) ? {$past(i_under_evt), $past(i_over_evt)} : '0))
    else $error("monitor pins do not echo detector flags");
  AST_OVR_ENTER: assert property ($rose(gpio[i_ovr_pin_sel]) && i_trig_unmask[i_ovr_pin_sel]
    |-> ##[2:4] (o_manual_gain_mode && o_gain_idx == {AGH_NUM_CH{i_manual_gain}}))
    else $error("override did not load manual gain");
  AST_OVR_EXIT: assert property ($fell(gpio[i_ovr_pin_sel]) && !i_pin_gain_en
    |-> ##[2:4] !o_manual_gain_mode)
    else $error("override release did not restore automatic mode");
  AST_OVR_MASK: assert property (!i_trig_unmask[i_ovr_pin_sel] && !i_pin_gain_en
    && !o_manual_gain_mode |=> !o_manual_gain_mode)
    else $error("masked pin entered manual mode");
  AST_OVR_HOLD: assert property (o_manual_gain_mode && $past(o_manual_gain_mode)
    && !i_pin_gain_en |-> $stable(o_gain_idx))
    else $error("gain moved during override");
  AST_NO_TRIG: assert property (o_manual_gain_mode && $past(o_manual_gain_mode) |-> o_over_trig == '0)
    else $error("trigger issued in manual mode");
  AST_TRIG_CAUSE: assert property (o_over_trig != '0 |-> (o_over_trig & ~$past(i_over_evt, 2)) == '0)
    else $error("trigger without a counted event");
  AST_PERIOD_GAP: assert property (o_peak_reset |=> !o_peak_reset)
    else $error("expiry pulse longer than one cycle");
  AST_PERIOD_BOUND: assert property (since_ff <= {1'b0, i_period_len} + 23'h000004)
    else $error("decision period overran its length");
endmodule : agh_properties

// ===== verif/tb_top.sv
// Self-checking bench joining controller and device over the link interface.
// Assumes the package and the link interface are compiled first.
`timescale 1ns/1ps
module tb_top;
  import agh_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, q, gain;
  logic wreq, irq, mode, pkr, hold = 1'b0, rsd = 1'b0, pge = 1'b0, mon_en = 1'b1;
  logic [3:0] ovr = 4'h0, und = 4'h0, otr, utr, seen;
  logic [3:0] sel = 4'h2;
  logic [15:0] unm = 16'h0000;
  logic [7:0] mg = 8'h00, gmax = 8'hFF;
  logic [21:0] plen = 22'h00003C;
  logic sen = 1'b1;
  int miscompares = 0, checks_done = 0, cyc = 0, n;
  agh_link_if lnk();
  agh_host u_agh_host (.i_ref_clk(clk), .i_rst(rst), .link(lnk), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_irq(irq));
  agh_device u_agh_device (.i_ref_clk(clk), .i_rst(rst), .link(lnk), .i_over_evt(ovr),
    .i_under_evt(und), .i_over_thresh(8'h01), .i_under_thresh(8'h01), .i_period_len(plen),
    .i_holdover_en(hold), .i_reset_state_on_rx_disable(rsd), .i_ovr_pin_sel(sel),
    .i_trig_unmask(unm), .i_manual_gain(mg), .i_sync_en(sen), .i_sync_pin_sel(4'h3),
    .i_pin_gain_en(pge), .i_mon_en(mon_en), .i_gain_min(8'h00), .i_gain_max(gmax),
    .o_gain_idx(gain), .o_manual_gain_mode(mode), .o_peak_reset(pkr), .o_over_trig(otr),
    .o_under_trig(utr));
  agh_properties u_agh_properties (.i_ref_clk(clk), .i_rst(rst), .rx_en(lnk.rx_en),
    .gpio(lnk.gpio), .mon(lnk.mon), .i_over_evt(ovr), .i_under_evt(und), .i_mon_en(mon_en),
    .i_pin_gain_en(pge), .i_ovr_pin_sel(sel), .i_trig_unmask(unm), .i_manual_gain(mg),
    .i_period_len(plen),
    .o_gain_idx(gain), .o_manual_gain_mode(mode), .o_peak_reset(pkr), .o_over_trig(otr));
  // Clock and hang guard
  initial
  begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      stop_test();
    end
  end
  task stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", s, e, g);
      miscompares++;
    end
  endtask : chk
  // One Avalon transfer held until waitrequest is sampled low
  task av(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : av
  task ev(input logic [7:0] v);
    @(posedge clk);
    {und, ovr} <= v;
    @(posedge clk);
    {und, ovr} <= 8'h00;
  endtask : ev
  task wait_peak();
    n = 0;
    @(posedge clk);
    while (pkr !== 1'b1)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_peak
  // One event, receive disable, one event: only holdover lets the pair trigger
  task trig_run(input logic h, input logic [3:0] e);
    hold <= h;
    av(1'b1, AGH_REG_CTRL, 32'h1);
    wait_peak();
    ev(8'h0F);
    av(1'b1, AGH_REG_CTRL, 32'h0);
    repeat (5) @(posedge clk);
    ev(8'h0F);
    seen = 4'h0;
    repeat (6) @(posedge clk) seen |= otr;
    chk("trigger", {28'h0, e}, {28'h0, seen});
  endtask : trig_run
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    av(1'b0, AGH_REG_GPIO, 32'h0);
    chk("gpio", 32'h0, q);
    chk("gain", {4{AGH_GAIN_RST}}, gain);
    $display("reset test done");
    mg <= 8'h3C;
    unm <= 16'h0004;
    av(1'b1, AGH_REG_GPIO, 32'h4);
    repeat (5) @(posedge clk);
    chk("mode", 32'h1, {31'h0, mode});
    chk("gain", {4{8'h3C}}, gain);
    av(1'b1, AGH_REG_GPIO, 32'h0);
    repeat (5) @(posedge clk);
    chk("mode", 32'h0, {31'h0, mode});
    unm <= 16'h0000;
    av(1'b1, AGH_REG_GPIO, 32'h4);
    repeat (5) @(posedge clk);
    chk("mode", 32'h0, {31'h0, mode});
    pge <= 1'b1;
    av(1'b1, AGH_REG_GPIO, 32'h5A00);
    repeat (5) @(posedge clk);
    chk("pin gain", 32'h5A, {24'h0, gain[7:0]});
    pge <= 1'b0;
    av(1'b1, AGH_REG_GPIO, 32'h0);
    $display("override test done");
    trig_run(1'b0, 4'h0);
    trig_run(1'b1, 4'hF);
    // Two underrange events in one period raise the underrange trigger
    wait_peak();
    ev(8'hF0);
    ev(8'hF0);
    seen = 4'h0;
    repeat (6) @(posedge clk) seen |= utr;
    chk("under trigger", 32'hF, {28'h0, seen});
    rsd <= 1'b1;
    gmax <= 8'hF0;
    av(1'b1, AGH_REG_CTRL, 32'h1);
    av(1'b1, AGH_REG_CTRL, 32'h0);
    repeat (5) @(posedge clk);
    chk("gain", {4{8'hF0}}, gain);
    // Slot pulse with alignment disabled leaves the period alone
    sen <= 1'b0;
    wait_peak();
    av(1'b1, AGH_REG_SLOT, 32'h3);
    wait_peak();
    chk("no realign", 32'h1, {31'h0, n < 62});
    sen <= 1'b1;
    wait_peak();
    av(1'b1, AGH_REG_SLOT, 32'h3);
    wait_peak();
    chk("realign", 32'h1, {31'h0, n > 62 && n < 75});
    $display("counter test done");
    av(1'b1, AGH_REG_IRQ_CLR, 32'hFF);
    av(1'b1, AGH_REG_IRQ_EN, 32'h1);
    ev(8'hFF);
    repeat (6) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    av(1'b0, AGH_REG_IRQ_STAT, 32'h0);
    chk("stat", 32'hFF, q);
    av(1'b1, AGH_REG_IRQ_CLR, 32'hFF);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    av(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h0, q);
    // Monitor disabled: detector flags must not reach the status bits
    mon_en <= 1'b0;
    ev(8'hFF);
    repeat (6) @(posedge clk);
    av(1'b0, AGH_REG_IRQ_STAT, 32'h0);
    chk("masked stat", 32'h0, q);
    $display("monitor test done");
    stop_test();
  end
endmodule : tb_top
